// File: rtl/cdadj_defs.vh
// Constants for the complement and decimal adjust datapath
// How it works
// (RULE_01) Accumulator complement inverts every accumulator bit, flags untouched, one cycle.
// (RULE_02) Bit complement 1011 0010 inverts the addressed bit only, one cycle.
// (RULE_03) Port bit complement reads the output latch, never the pin level.
// (RULE_04) Carry complement 1011 0011 inverts carry; any direct bit may be complemented.
// (RULE_05) Decimal adjust adds six when low nibble exceeds nine or aux carry set.
// (RULE_06) Low-nibble correction sets carry on carry-out, never clears it.
// (RULE_07) Then adds six to upper nibble if carry set or upper nibble exceeds nine.
// (RULE_08) Upper correction carry-out sets carry, never clears; overflow flag unchanged.
// (RULE_09) Net effect adds 00H, 06H, 60H or 66H; one-byte opcode 1101 0100.
// (RULE_10) Both corrections and all flag updates finish in one machine cycle.
// (RULE_11) Nothing but the target operand and, for decimal adjust, carry changes; here last_op_ff also records each executed opcode.
`ifndef CDADJ_DEFS_VH
`define CDADJ_DEFS_VH

// ****************************************
// Opcodes
// ****************************************
`define CDADJ_OP_INV_ACC      8'hF4
`define CDADJ_OP_INV_BIT      8'hB2
`define CDADJ_OP_INV_CARRY    8'hB3
`define CDADJ_OP_DEC_ADJ      8'hD4

// ****************************************
// Decimal adjust constants
// ****************************************
`define CDADJ_NIBBLE_MAX      4'h9
`define CDADJ_ADJ_LOW         9'h006
`define CDADJ_ADJ_HIGH        9'h060

// ****************************************
// Register offsets and fields
// ****************************************
`define CDADJ_REG_CTRL        4'h0
`define CDADJ_REG_ACC         4'h4
`define CDADJ_REG_FLAGS       4'h8
`define CDADJ_REG_BITADDR     4'hC
`define CDADJ_FLAG_CARRY      0
`define CDADJ_FLAG_AUX        1
`define CDADJ_FLAG_OVF        2
`define CDADJ_FLAG_BITVAL     3
`define CDADJ_FLAG_PORT       4
`define CDADJ_FLAG_LATCH      5

`endif

// File: rtl/cdadj_decimal_adjust.v
// Combinational decimal adjust of the accumulator
`timescale 1ns/1ps
`include "cdadj_defs.vh"

module cdadj_decimal_adjust (
    input  wire [7:0] acc_in,
    input  wire       carry_in,
    input  wire       aux_carry_flag,
    output reg  [7:0] acc_out,
    output reg        carry_out
);

    reg [8:0] low_sum;
    reg       mid_carry;
    reg [8:0] high_sum;

    always @* begin
        low_sum   = {1'b0, acc_in};
        mid_carry = carry_in;
        if ((acc_in[3:0] > `CDADJ_NIBBLE_MAX) || aux_carry_flag) begin // RULE_05
            low_sum = {1'b0, acc_in} + `CDADJ_ADJ_LOW;
        end
        if (low_sum[8]) begin
            mid_carry = 1'b1; // RULE_06
        end
        high_sum = {1'b0, low_sum[7:0]};
        if (mid_carry || (low_sum[7:4] > `CDADJ_NIBBLE_MAX)) begin // RULE_07
            high_sum = {1'b0, low_sum[7:0]} + `CDADJ_ADJ_HIGH;
        end
        acc_out   = high_sum[7:0]; // RULE_09
        carry_out = mid_carry | high_sum[8]; // RULE_08
    end

endmodule

// File: rtl/cdadj_core.v
// Complement and decimal adjust datapath with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cdadj_defs.vh"

module cdadj_core (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bit_pin_in,
    output reg         bit_result_ff,
    output reg         bit_write_ff
);

    // ****************************************
    // Register state
    // ****************************************
    reg [7:0]  acc_ff;
    reg        carry_ff;
    reg        aux_carry_flag_ff;
    reg        overflow_flag_ff;
    reg        bit_val_ff;
    reg        bit_is_port_ff;
    reg        port_latch_ff;
    reg [7:0]  bit_addr_ff;
    reg [7:0]  last_op_ff;
    reg [2:0]  pin_sync_ff;
    reg        pin_level_ff;
    reg        aw_held_ff;
    reg        w_held_ff;
    reg [3:0]  aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;

    wire [7:0] adj_acc;
    wire       adj_carry;

    cdadj_decimal_adjust cdadj_decimal_adjust_i (
        .acc_in         (acc_ff),
        .carry_in       (carry_ff),
        .aux_carry_flag (aux_carry_flag_ff),
        .acc_out        (adj_acc),
        .carry_out      (adj_carry)
    );

    // ****************************************
    // Pin sampling
    // ****************************************
    // Pin level only observed for status; complement never uses it
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_ff  <= 3'h0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], bit_pin_in};
            if (pin_sync_ff[1] == pin_sync_ff[2]) begin
                pin_level_ff <= pin_sync_ff[2];
            end
        end
    end

    // ****************************************
    // Write channel acceptance
    // ****************************************
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire aw_have  = aw_held_ff | aw_take;
    wire w_have   = w_held_ff | w_take;
    wire wr_go    = aw_have & w_have & ~s_axi_bvalid;
    wire [3:0]  wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
    wire        wr_b0   = wr_strb[0];
    wire [7:0]  opcode  = wr_data[7:0];
    wire        exec    = wr_go & wr_b0 & (wr_addr == `CDADJ_REG_CTRL);

    // Operand for bit complement: port bits come from the latch
    wire bit_src = bit_is_port_ff ? port_latch_ff : bit_val_ff; // RULE_03

    reg        nxt_awready;
    reg        nxt_wready;
    reg        nxt_bvalid;
    reg [1:0]  nxt_bresp;
    reg        nxt_aw_held;
    reg        nxt_w_held;
    reg [3:0]  nxt_aw_addr;
    reg [31:0] nxt_w_data;
    reg [3:0]  nxt_w_strb;

    // Ready pulses on idle cycles; a channel taken early waits for its partner
    always @* begin
        nxt_awready = ~aw_have & ~s_axi_awready & ~s_axi_bvalid;
        nxt_wready  = ~w_have & ~s_axi_wready & ~s_axi_bvalid;
        nxt_bvalid  = s_axi_bvalid;
        nxt_bresp   = s_axi_bresp;
        nxt_aw_held = aw_held_ff;
        nxt_w_held  = w_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        if (aw_take) begin
            nxt_aw_held = 1'h1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            nxt_w_held = 1'h1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw_held = 1'h0;
            nxt_w_held  = 1'h0;
            nxt_awready = 1'h0;
            nxt_wready  = 1'h0;
            nxt_bvalid  = 1'h1;
            nxt_bresp   = (wr_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end else if (s_axi_bvalid && s_axi_bready) begin
            nxt_bvalid = 1'h0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'h0;
            s_axi_wready  <= 1'h0;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= 2'h0;
            aw_held_ff    <= 1'h0;
            w_held_ff     <= 1'h0;
            aw_addr_ff    <= 4'h0;
            w_data_ff     <= 32'h0;
            w_strb_ff     <= 4'h0;
        end else begin
            s_axi_awready <= nxt_awready;
            s_axi_wready  <= nxt_wready;
            s_axi_bvalid  <= nxt_bvalid;
            s_axi_bresp   <= nxt_bresp;
            aw_held_ff    <= nxt_aw_held;
            w_held_ff     <= nxt_w_held;
            aw_addr_ff    <= nxt_aw_addr;
            w_data_ff     <= nxt_w_data;
            w_strb_ff     <= nxt_w_strb;
        end
    end

    // ****************************************
    // Instruction execution and register writes
    // ****************************************
    reg [7:0]  nxt_acc;
    reg        nxt_carry;
    reg        nxt_aux_carry_flag;
    reg        nxt_overflow_flag;
    reg        nxt_bit_val;
    reg        nxt_bit_is_port;
    reg        nxt_port_latch;
    reg [7:0]  nxt_bit_addr;
    reg [7:0]  nxt_last_op;
    reg        nxt_bit_result;
    reg        nxt_bit_write;

    wire wr_acc   = wr_go & wr_b0 & (wr_addr == `CDADJ_REG_ACC);
    wire wr_flags = wr_go & wr_b0 & (wr_addr == `CDADJ_REG_FLAGS);
    wire wr_bitad = wr_go & wr_b0 & (wr_addr == `CDADJ_REG_BITADDR);

    // Each executed opcode touches only its own target and the last-opcode readback last_op_ff
    always @* begin
        nxt_acc            = acc_ff;
        nxt_carry          = carry_ff;
        nxt_aux_carry_flag = aux_carry_flag_ff;
        nxt_overflow_flag  = overflow_flag_ff;
        nxt_bit_val        = bit_val_ff;
        nxt_bit_is_port    = bit_is_port_ff;
        nxt_port_latch     = port_latch_ff;
        nxt_bit_addr       = bit_addr_ff;
        nxt_last_op        = last_op_ff;
        nxt_bit_result     = bit_result_ff;
        nxt_bit_write      = 1'h0;
        if (exec) begin
            case (opcode)
                `CDADJ_OP_INV_ACC: begin
                    nxt_acc     = ~acc_ff; // RULE_01
                    nxt_last_op = opcode;
                end
                `CDADJ_OP_INV_BIT: begin
                    nxt_bit_result = ~bit_src; // RULE_02
                    nxt_bit_write  = 1'h1;
                    nxt_last_op    = opcode;
                    if (bit_is_port_ff) begin
                        nxt_port_latch = ~port_latch_ff; // RULE_03
                    end else begin
                        nxt_bit_val = ~bit_val_ff; // RULE_04
                    end
                end
                `CDADJ_OP_INV_CARRY: begin
                    nxt_carry   = ~carry_ff; // RULE_04
                    nxt_last_op = opcode;
                end
                `CDADJ_OP_DEC_ADJ: begin
                    // Aux carry and overflow keep their value
                    nxt_acc     = adj_acc; // RULE_10
                    nxt_carry   = adj_carry; // RULE_11
                    nxt_last_op = opcode;
                end
                default: begin
                    // Unknown opcodes leave no trace, not even in the readback
                    nxt_last_op = last_op_ff;
                end
            endcase
        end else if (wr_acc) begin
            nxt_acc = wr_data[7:0];
        end else if (wr_flags) begin
            nxt_carry          = wr_data[`CDADJ_FLAG_CARRY];
            nxt_aux_carry_flag = wr_data[`CDADJ_FLAG_AUX];
            nxt_overflow_flag  = wr_data[`CDADJ_FLAG_OVF];
            nxt_bit_val        = wr_data[`CDADJ_FLAG_BITVAL];
            nxt_bit_is_port    = wr_data[`CDADJ_FLAG_PORT];
            nxt_port_latch     = wr_data[`CDADJ_FLAG_LATCH];
        end else if (wr_bitad) begin
            nxt_bit_addr = wr_data[7:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff            <= 8'h00;
            carry_ff          <= 1'h0;
            aux_carry_flag_ff <= 1'h0;
            overflow_flag_ff  <= 1'h0;
            bit_val_ff        <= 1'h0;
            bit_is_port_ff    <= 1'h0;
            port_latch_ff     <= 1'h0;
            bit_addr_ff       <= 8'h00;
            last_op_ff        <= 8'h00;
            bit_result_ff     <= 1'h0;
            bit_write_ff      <= 1'h0;
        end else begin
            acc_ff            <= nxt_acc;
            carry_ff          <= nxt_carry;
            aux_carry_flag_ff <= nxt_aux_carry_flag;
            overflow_flag_ff  <= nxt_overflow_flag;
            bit_val_ff        <= nxt_bit_val;
            bit_is_port_ff    <= nxt_bit_is_port;
            port_latch_ff     <= nxt_port_latch;
            bit_addr_ff       <= nxt_bit_addr;
            last_op_ff        <= nxt_last_op;
            bit_result_ff     <= nxt_bit_result;
            bit_write_ff      <= nxt_bit_write;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    reg [31:0] rd_mux;

    always @* begin
        case (s_axi_araddr)
            `CDADJ_REG_CTRL:    rd_mux = {24'h0, last_op_ff};
            `CDADJ_REG_ACC:     rd_mux = {24'h0, acc_ff};
            `CDADJ_REG_FLAGS:   rd_mux = {25'h0, pin_level_ff, port_latch_ff, bit_is_port_ff,
                                          bit_val_ff, overflow_flag_ff, aux_carry_flag_ff,
                                          carry_ff};
            `CDADJ_REG_BITADDR: rd_mux = {24'h0, bit_addr_ff};
            default:            rd_mux = 32'h0;
        endcase
    end

    reg        nxt_arready;
    reg        nxt_rvalid;
    reg [31:0] nxt_rdata;
    reg [1:0]  nxt_rresp;

    // Address is not stored, so the master must hold it until arready
    always @* begin
        nxt_arready = ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        nxt_rvalid  = s_axi_rvalid;
        nxt_rdata   = s_axi_rdata;
        nxt_rresp   = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_arready = 1'h0;
            nxt_rvalid  = 1'h1;
            nxt_rdata   = rd_mux;
            nxt_rresp   = (s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            nxt_rvalid = 1'h0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= nxt_arready;
            s_axi_rvalid  <= nxt_rvalid;
            s_axi_rdata   <= nxt_rdata;
            s_axi_rresp   <= nxt_rresp;
        end
    end

endmodule

// File: bench/cdadj_pin_model.sv
// Model of the external port pin seen by the datapath
`timescale 1ns/1ps
module cdadj_pin_model (
    input  wire  aclk,
    input  wire  bit_result_ff,
    output logic bit_pin_in
);
    initial bit_pin_in = 1'b1;
    // Pin shows the opposite of bit_result_ff one cycle later, so a pin read gives a wrong result
    always @(posedge aclk) bit_pin_in <= ~bit_result_ff;
endmodule

// File: bench/cdadj_core_sva.sv
// Port checks for the complement and decimal adjust datapath
`timescale 1ns/1ps
module cdadj_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        bit_result_ff,
    input wire        bit_write_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_awpls; s_axi_awready |=> !s_axi_awready; endproperty
    a_awpls: assert property (p_awpls) else $error("awready not a pulse");
    property p_noaw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_noaw: assert property (p_noaw) else $error("write taken during response");
    property p_arlat; $rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready; endproperty
    a_arlat: assert property (p_arlat) else $error("arready late");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("rvalid late");
    property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rhi: assert property (p_rhi) else $error("upper read bits set");
    property p_bwpls; bit_write_ff |=> !bit_write_ff; endproperty
    a_bwpls: assert property (p_bwpls) else $error("bit write not a pulse");
    property p_bwcause; bit_write_ff |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_bwcause: assert property (p_bwcause) else $error("bit write without write");
    property p_bres; $changed(bit_result_ff) |-> bit_write_ff; endproperty
    a_bres: assert property (p_bres) else $error("bit result moved alone");
endmodule
bind cdadj_core cdadj_chk cdadj_chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .bit_result_ff, .bit_write_ff);

// File: bench/cdadj_core_bench.sv
// Self-checking bench for the complement and decimal adjust datapath
`timescale 1ns/1ps
module cdadj_core_bench;
    logic        aclk = 0, aresetn = 0;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         bit_pin_in, bit_result_ff, bit_write_ff;
    logic [31:0] rd_q;
    logic [1:0]  resp_q;
    int          error_cnt = 0, checks = 0;
    initial forever #5 aclk = ~aclk;
    cdadj_core cdadj_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_pin_in,
        .bit_result_ff, .bit_write_ff);
    cdadj_pin_model cdadj_pin_model_i (.aclk, .bit_result_ff, .bit_pin_in);
    task chk(input string n, input [31:0] s, input [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rchk(input string n, input [3:0] a, input [7:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // Bit 6 follows the pin, so flags compare only bits 5..0
        chk(n, rd_q & (a == 4'h8 ? 32'h3F : 32'hFF), {24'h0, e});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rchk("acc", 4'h4, 8'h00);
        rchk("flags", 4'h8, 8'h00);
        rchk("ctrl", 4'h0, 8'h00);
        chk("rresp", resp_q, 2'h0);
        $display("t_reset done");
    endtask
    task t_cpl_acc;
        wr(4'h4, 8'h5C);
        wr(4'h8, 8'h27);
        wr(4'h0, 8'hF4);
        chk("bresp", resp_q, 2'h0);
        rchk("acc", 4'h4, 8'hA3);
        rchk("flags", 4'h8, 8'h27);
        wr(4'h0, 8'h00);
        rchk("acc", 4'h4, 8'hA3);
        rchk("ctrl", 4'h0, 8'hF4);
        wr(4'h5, 8'h55);
        chk("bresp", resp_q, 2'h2);
        rchk("acc", 4'h4, 8'hA3);
        rchk("unaligned", 4'h2, 8'h00);
        chk("rresp", resp_q, 2'h2);
        $display("t_cpl_acc done");
    endtask
    task t_cpl_bit;
        wr(4'h8, 8'h00);
        wr(4'h0, 8'hB2);
        rchk("flags", 4'h8, 8'h08);
        chk("bit_result", bit_result_ff, 1'b1);
        // Latch set while the pin shows low: a pin read would give the wrong result
        wr(4'h8, 8'h31);
        wr(4'h0, 8'hB2);
        rchk("flags", 4'h8, 8'h11);
        chk("bit_result", bit_result_ff, 1'b0);
        wr(4'h0, 8'hB2);
        rchk("flags", 4'h8, 8'h31);
        chk("bit_result", bit_result_ff, 1'b1);
        wr(4'h8, 8'h00);
        wr(4'h0, 8'hB3);
        rchk("flags", 4'h8, 8'h01);
        wr(4'h0, 8'hB3);
        rchk("flags", 4'h8, 8'h00);
        $display("t_cpl_bit done");
    endtask
    task dec_case(input [7:0] a, input [7:0] f, input [7:0] ea, input ec);
        wr(4'h4, a);
        wr(4'h8, f);
        wr(4'h0, 8'hD4);
        rchk("adj_acc", 4'h4, ea);
        rchk("adj_flags", 4'h8, {f[7:1], ec});
    endtask
    task t_dec_adj;
        dec_case(8'hBE, 8'h00, 8'h24, 1'b1);
        dec_case(8'hC9, 8'h04, 8'h29, 1'b1);
        dec_case(8'h56, 8'h06, 8'h5C, 1'b0);
        dec_case(8'h99, 8'h01, 8'hF9, 1'b1);
        dec_case(8'h9A, 8'h04, 8'h00, 1'b1);
        dec_case(8'hFA, 8'h00, 8'h60, 1'b1);
        dec_case(8'h34, 8'h07, 8'h9A, 1'b1);
        dec_case(8'h45, 8'h04, 8'h45, 1'b0);
        $display("t_dec_adj done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_cpl_acc;
        t_cpl_bit;
        t_dec_adj;
        wrap_up;
    end
    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
endmodule
